// ---- core/afe_pkg.sv ----
// afe_pkg: shared constants for the analog front end setting broadcaster
package afe_pkg;
    localparam int NUM_CH      = 2;
    localparam int SWING_W     = 3;
    localparam int PREEMP_W    = 5;
    localparam int DCGAIN_W    = 2;
    localparam int EQ_W        = 4;
    localparam int SLICE_W     = SWING_W + PREEMP_W + DCGAIN_W + EQ_W;
    localparam int SWING_POS   = 0;
    localparam int PREEMP_POS  = SWING_POS + SWING_W;
    localparam int DCGAIN_POS  = PREEMP_POS + PREEMP_W;
    localparam int EQ_POS      = DCGAIN_POS + DCGAIN_W;
    // cycles spent per channel moving one setting slice
    localparam int CH_CYCLES   = 4;
    localparam int CNT_W       = 3;
    localparam int CH_IDX_W    = 2;
    // direction select encodings
    localparam logic [1:0] DIR_BOTH = 2'h3;
    localparam logic [1:0] DIR_TX   = 2'h2;
    localparam logic [1:0] DIR_RX   = 2'h1;
    localparam logic [SLICE_W-1:0] SLICE_RESET = 14'h0000;
endpackage

// ---- core/afe_if.sv ----
// afe_if: carrier between user-side initiator and the setting controller
`timescale 1ns/1ps
interface afe_if;
    logic                                       write_all;
    logic                                       read;
    logic [1:0]                                 dir_sel;
    logic                                       shared_mode;
    logic [afe_pkg::NUM_CH*afe_pkg::SWING_W-1:0]  swing;
    logic [afe_pkg::NUM_CH*afe_pkg::PREEMP_W-1:0] preemp;
    logic [afe_pkg::NUM_CH*afe_pkg::DCGAIN_W-1:0] dcgain;
    logic [afe_pkg::NUM_CH*afe_pkg::EQ_W-1:0]     eq;
    logic                                       busy;
    logic                                       data_valid;
    logic [afe_pkg::NUM_CH*afe_pkg::SWING_W-1:0]  swing_out;
    logic [afe_pkg::NUM_CH*afe_pkg::PREEMP_W-1:0] preemp_out;
    logic [afe_pkg::NUM_CH*afe_pkg::DCGAIN_W-1:0] dcgain_out;
    logic [afe_pkg::NUM_CH*afe_pkg::EQ_W-1:0]     eq_out;
    modport ctrl (
        input  write_all, read, dir_sel, shared_mode, swing, preemp, dcgain, eq,
        output busy, data_valid, swing_out, preemp_out, dcgain_out, eq_out
    );
    modport user (
        output write_all, read, dir_sel, shared_mode, swing, preemp, dcgain, eq,
        input  busy, data_valid, swing_out, preemp_out, dcgain_out, eq_out
    );
endinterface

// ---- core/afe_chan.sv ----
// afe_chan: one transceiver channel's analog setting store
`timescale 1ns/1ps
module afe_chan (
    input  wire logic                            i_clk_sys,
    input  wire logic                            i_resetn,
    input  wire logic                            i_wr,
    input  wire logic [1:0]                      i_dir,
    input  wire logic [afe_pkg::SLICE_W-1:0]     i_slice,
    output logic      [afe_pkg::SLICE_W-1:0]     o_slice
);
    typedef struct packed {
        logic [afe_pkg::SLICE_W-1:0] set;
    } afe_chan_st_t;

    afe_chan_st_t st;
    afe_chan_st_t next_st;

    // ==========================================================
    // update: tx fields (swing, preemp) and rx fields gated apart
    always_comb begin
        next_st = st;
        if (i_wr && i_dir[1]) begin
            next_st.set[afe_pkg::PREEMP_POS+afe_pkg::PREEMP_W-1:afe_pkg::SWING_POS] =
                i_slice[afe_pkg::PREEMP_POS+afe_pkg::PREEMP_W-1:afe_pkg::SWING_POS];
        end
        if (i_wr && i_dir[0]) begin
            next_st.set[afe_pkg::SLICE_W-1:afe_pkg::DCGAIN_POS] =
                i_slice[afe_pkg::SLICE_W-1:afe_pkg::DCGAIN_POS];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            st.set <= afe_pkg::SLICE_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign o_slice = st.set;
endmodule

// ---- core/afe_ctrl.sv ----
// afe_ctrl: device end, broadcasts or reads analog settings of all channels
`timescale 1ns/1ps
module afe_ctrl (
    input  wire logic   i_clk_sys,
    input  wire logic   i_resetn,
    afe_if.ctrl         bus
);
    typedef enum logic [1:0] {
        IDLE,
        WRITE,
        READ
    } afe_state_t;

    typedef struct packed {
        afe_state_t                                   state;
        logic [afe_pkg::CH_IDX_W-1:0]                 ch;
        logic [afe_pkg::CNT_W-1:0]                    cnt;
        logic [1:0]                                   dir;
        logic                                         valid;
        logic [afe_pkg::NUM_CH*afe_pkg::SLICE_W-1:0]  rd;
        logic [afe_pkg::NUM_CH*afe_pkg::SLICE_W-1:0]  stage;
    } afe_ctrl_st_t;

    afe_ctrl_st_t st;
    afe_ctrl_st_t next_st;

    logic [afe_pkg::NUM_CH-1:0]                 ch_wr;
    logic [afe_pkg::SLICE_W-1:0]                wr_slice [afe_pkg::NUM_CH];
    logic [afe_pkg::SLICE_W-1:0]                ch_set   [afe_pkg::NUM_CH];
    logic                                       last_cycle;
    logic                                       last_ch;
    logic                                       tx_sel;
    logic                                       rx_sel;
    logic [afe_pkg::SLICE_W-1:0]                cur_set;

    // ==========================================================
    // channel slices
    for (genvar c = 0; c < afe_pkg::NUM_CH; c++) begin : g_ch
        always_comb begin
            if (bus.shared_mode) begin
                // fixed-width word from the low slice goes to every channel
                wr_slice[c] = {bus.eq[afe_pkg::EQ_W-1:0],
                               bus.dcgain[afe_pkg::DCGAIN_W-1:0],
                               bus.preemp[afe_pkg::PREEMP_W-1:0],
                               bus.swing[afe_pkg::SWING_W-1:0]};
            end else begin
                wr_slice[c] = {bus.eq[c*afe_pkg::EQ_W +: afe_pkg::EQ_W],
                               bus.dcgain[c*afe_pkg::DCGAIN_W +: afe_pkg::DCGAIN_W],
                               bus.preemp[c*afe_pkg::PREEMP_W +: afe_pkg::PREEMP_W],
                               bus.swing[c*afe_pkg::SWING_W +: afe_pkg::SWING_W]};
            end
        end

        // each channel is visited in turn, so none is skipped
        assign ch_wr[c] = (st.state == WRITE) && last_cycle
                          && (st.ch == afe_pkg::CH_IDX_W'(c));

        afe_chan i_afe_chan (
            .i_clk_sys (i_clk_sys),
            .i_resetn  (i_resetn),
            .i_wr      (ch_wr[c]),
            .i_dir     (st.dir),
            .i_slice   (wr_slice[c]),
            .o_slice   (ch_set[c])
        );

        assign bus.swing_out[c*afe_pkg::SWING_W +: afe_pkg::SWING_W] =
            st.rd[c*afe_pkg::SLICE_W+afe_pkg::SWING_POS +: afe_pkg::SWING_W];
        assign bus.preemp_out[c*afe_pkg::PREEMP_W +: afe_pkg::PREEMP_W] =
            st.rd[c*afe_pkg::SLICE_W+afe_pkg::PREEMP_POS +: afe_pkg::PREEMP_W];
        assign bus.dcgain_out[c*afe_pkg::DCGAIN_W +: afe_pkg::DCGAIN_W] =
            st.rd[c*afe_pkg::SLICE_W+afe_pkg::DCGAIN_POS +: afe_pkg::DCGAIN_W];
        assign bus.eq_out[c*afe_pkg::EQ_W +: afe_pkg::EQ_W] =
            st.rd[c*afe_pkg::SLICE_W+afe_pkg::EQ_POS +: afe_pkg::EQ_W];
    end

    // ==========================================================
    // slot timing and field masks
    assign last_cycle = (st.cnt == afe_pkg::CNT_W'(afe_pkg::CH_CYCLES - 1));
    assign last_ch    = (st.ch == afe_pkg::CH_IDX_W'(afe_pkg::NUM_CH - 1));
    assign tx_sel     = st.dir[1];
    assign rx_sel     = st.dir[0];

    // only existing channels are indexed, so a stray count reads zeros
    always_comb begin
        cur_set = afe_pkg::SLICE_RESET;
        for (int k = 0; k < afe_pkg::NUM_CH; k++) begin
            if (st.ch == afe_pkg::CH_IDX_W'(k)) begin
                cur_set = ch_set[k];
            end
        end
    end

    // ==========================================================
    // sequencer
    always_comb begin
        next_st = st;
        unique case (st.state)
            IDLE: begin
                // write wins if both strobes arrive together
                if (bus.write_all) begin
                    next_st.state = WRITE;
                    next_st.ch    = '0;
                    next_st.cnt   = '0;
                    next_st.dir   = bus.dir_sel;
                    next_st.valid = 1'b0;
                    next_st.stage = st.rd;
                end else if (bus.read) begin
                    next_st.state = READ;
                    next_st.ch    = '0;
                    next_st.cnt   = '0;
                    next_st.dir   = bus.dir_sel;
                    next_st.valid = 1'b0;
                    // fields outside the direction keep what the last read returned
                    next_st.stage = st.rd;
                end
            end
            WRITE: begin
                // strobes are not looked at here; ch_wr fires at each slot end
                next_st.cnt = st.cnt + afe_pkg::CNT_W'(1);
                if (last_cycle) begin
                    next_st.cnt = '0;
                    next_st.ch  = st.ch + afe_pkg::CH_IDX_W'(1);
                    // last channel stored: back to idle, busy drops
                    if (last_ch) begin
                        next_st.state = IDLE;
                        next_st.ch    = '0;
                    end
                end
            end
            READ: begin
                // staged so the read-back outputs move only together with valid
                next_st.cnt = st.cnt + afe_pkg::CNT_W'(1);
                if (last_cycle) begin
                    next_st.cnt = '0;
                    next_st.ch  = st.ch + afe_pkg::CH_IDX_W'(1);
                    if (tx_sel) begin
                        // tx fields: swing and pre-emphasis
                        next_st.stage[st.ch*afe_pkg::SLICE_W+afe_pkg::SWING_POS +:
                                      afe_pkg::SWING_W] =
                            cur_set[afe_pkg::SWING_POS +: afe_pkg::SWING_W];
                        next_st.stage[st.ch*afe_pkg::SLICE_W+afe_pkg::PREEMP_POS +:
                                      afe_pkg::PREEMP_W] =
                            cur_set[afe_pkg::PREEMP_POS +: afe_pkg::PREEMP_W];
                    end
                    if (rx_sel) begin
                        // rx fields: dc gain and equalizer
                        next_st.stage[st.ch*afe_pkg::SLICE_W+afe_pkg::DCGAIN_POS +:
                                      afe_pkg::DCGAIN_W] =
                            cur_set[afe_pkg::DCGAIN_POS +: afe_pkg::DCGAIN_W];
                        next_st.stage[st.ch*afe_pkg::SLICE_W+afe_pkg::EQ_POS +:
                                      afe_pkg::EQ_W] =
                            cur_set[afe_pkg::EQ_POS +: afe_pkg::EQ_W];
                    end
                    if (last_ch) begin
                        next_st.state = IDLE;
                        next_st.ch    = '0;
                        next_st.valid = 1'b1;
                        next_st.rd    = next_st.stage;
                    end
                end
            end
            default: next_st.state = IDLE;
        endcase
    end

    // ==========================================================
    // state register
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            st.state <= IDLE;
            st.ch    <= '0;
            st.cnt   <= '0;
            st.dir   <= afe_pkg::DIR_BOTH;
            st.valid <= 1'b0;
            st.rd    <= '0;
            st.stage <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // status outputs
    // busy is decoded from state, so it rises the edge after the strobe
    assign bus.busy       = (st.state != IDLE);
    assign bus.data_valid = st.valid;
endmodule

// ---- core/afe_user.sv ----
// afe_user: initiator end, turns user requests into one-cycle strobes
`timescale 1ns/1ps
module afe_user (
    input  wire logic                                       i_clk_sys,
    input  wire logic                                       i_resetn,
    input  wire logic                                       i_wr_req,
    input  wire logic                                       i_rd_req,
    input  wire logic                                       i_shared,
    input  wire logic                                       i_tx_only,
    input  wire logic                                       i_rx_only,
    input  wire logic [afe_pkg::NUM_CH*afe_pkg::SWING_W-1:0]  i_swing,
    input  wire logic [afe_pkg::NUM_CH*afe_pkg::PREEMP_W-1:0] i_preemp,
    input  wire logic [afe_pkg::NUM_CH*afe_pkg::DCGAIN_W-1:0] i_dcgain,
    input  wire logic [afe_pkg::NUM_CH*afe_pkg::EQ_W-1:0]     i_eq,
    output logic                                            o_accept,
    output logic                                            o_busy,
    output logic                                            o_rd_valid,
    output logic      [afe_pkg::NUM_CH*afe_pkg::SWING_W-1:0]  o_swing,
    output logic      [afe_pkg::NUM_CH*afe_pkg::PREEMP_W-1:0] o_preemp,
    output logic      [afe_pkg::NUM_CH*afe_pkg::DCGAIN_W-1:0] o_dcgain,
    output logic      [afe_pkg::NUM_CH*afe_pkg::EQ_W-1:0]     o_eq,
    afe_if.user                                             bus
);
    typedef struct packed {
        logic                                          wr;
        logic                                          rd;
        logic                                          pend;
        logic [1:0]                                    dir;
        logic                                          shared;
        logic [afe_pkg::NUM_CH*afe_pkg::SWING_W-1:0]   swing;
        logic [afe_pkg::NUM_CH*afe_pkg::PREEMP_W-1:0]  preemp;
        logic [afe_pkg::NUM_CH*afe_pkg::DCGAIN_W-1:0]  dcgain;
        logic [afe_pkg::NUM_CH*afe_pkg::EQ_W-1:0]      eq;
    } afe_user_st_t;

    afe_user_st_t st;
    afe_user_st_t next_st;
    logic         idle;

    // pend covers the edge between the strobe and busy rising
    assign idle = !bus.busy && !st.pend && !st.wr && !st.rd;

    // ==========================================================
    // request capture
    always_comb begin
        next_st      = st;
        next_st.wr   = 1'b0;
        next_st.rd   = 1'b0;
        next_st.pend = st.wr || st.rd;
        if (idle && (i_wr_req || i_rd_req)) begin
            next_st.wr = i_wr_req;
            next_st.rd = !i_wr_req;
            next_st.dir = i_tx_only ? afe_pkg::DIR_TX :
                          (i_rx_only ? afe_pkg::DIR_RX : afe_pkg::DIR_BOTH);
            next_st.shared = i_shared;
            if (i_wr_req) begin
                // held until the next write request, so stable for the transaction
                next_st.swing  = i_swing;
                next_st.preemp = i_preemp;
                next_st.dcgain = i_dcgain;
                next_st.eq     = i_eq;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            st <= '0;
            st.dir <= afe_pkg::DIR_BOTH;
        end else begin
            st <= next_st;
        end
    end

    assign bus.write_all   = st.wr;
    assign bus.read        = st.rd;
    assign bus.dir_sel     = st.dir;
    assign bus.shared_mode = st.shared;
    assign bus.swing       = st.swing;
    assign bus.preemp      = st.preemp;
    assign bus.dcgain      = st.dcgain;
    assign bus.eq          = st.eq;

    assign o_accept   = idle && (i_wr_req || i_rd_req);
    assign o_busy     = !idle;
    assign o_rd_valid = bus.data_valid;
    assign o_swing    = bus.swing_out;
    assign o_preemp   = bus.preemp_out;
    assign o_dcgain   = bus.dcgain_out;
    assign o_eq       = bus.eq_out;
endmodule

// ---- verification/afe_ctrl_sva.sv ----
// afe_ctrl_sva: protocol checks on the carrier between user and controller ends
`timescale 1ns/1ps
module afe_ctrl_sva (
    input wire logic        i_clk_sys,
    input wire logic        i_resetn,
    input wire logic        write_all,
    input wire logic        read,
    input wire logic [1:0]  dir_sel,
    input wire logic [5:0]  swing,
    input wire logic [9:0]  preemp,
    input wire logic [3:0]  dcgain,
    input wire logic [7:0]  eq,
    input wire logic        busy,
    input wire logic        data_valid,
    input wire logic [5:0]  swing_out,
    input wire logic [3:0]  dcgain_out
);
    // ==========================================
    // sequences
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);
    sequence s_wr_start; write_all && !busy; endsequence
    sequence s_rd_start; read && !busy; endsequence
    // one slot of 4 cycles per channel, two channels
    sequence s_busy_run; busy [*8] ##1 !busy; endsequence
    // ==========================================
    // properties
    property p_strobe_one; (write_all || read) |=> !(write_all || read); endproperty
    property p_strobe_idle; (write_all || read) |-> !busy; endproperty
    property p_no_both; !(write_all && read); endproperty
    property p_busy_start; (write_all || read) && !busy |=> s_busy_run; endproperty
    // busy length fixed even if strobes arrive meanwhile
    property p_busy_fixed; $rose(busy) |-> s_busy_run; endproperty
    property p_read_done; s_rd_start |=> !data_valid [*8] ##1 (data_valid && !busy);
    endproperty
    property p_write_quiet; s_wr_start |=> !data_valid [*8] ##1 !data_valid; endproperty
    property p_hold_set;
        s_wr_start |=> ($stable(swing) && $stable(preemp) && $stable(dcgain) && $stable(eq)) [*8];
    endproperty
    property p_dir_legal; (write_all || read) |-> dir_sel != 2'h0; endproperty
    property p_rb_on_valid;
        !$stable(swing_out) || !$stable(dcgain_out) |-> $rose(data_valid);
    endproperty
    a_strobe_one: assert property (p_strobe_one) else $error("strobe longer than one cycle");
    a_strobe_idle: assert property (p_strobe_idle) else $error("strobe while busy");
    a_no_both: assert property (p_no_both) else $error("write and read together");
    a_busy_start: assert property (p_busy_start) else $error("busy run wrong");
    a_busy_fixed: assert property (p_busy_fixed) else $error("busy length wrong");
    a_read_done: assert property (p_read_done) else $error("read end wrong");
    a_write_quiet: assert property (p_write_quiet) else $error("valid after write");
    a_hold_set: assert property (p_hold_set) else $error("settings moved in write");
    a_dir_legal: assert property (p_dir_legal) else $error("bad direction");
    a_rb_on_valid: assert property (p_rb_on_valid) else $error("read-back moved");
endmodule

// ---- verification/tb_afe_setting_broadcast_ctrl.sv ----
// tb_afe_setting_broadcast_ctrl: end-to-end bench of user and controller ends
`timescale 1ns/1ps
module tb_afe_setting_broadcast_ctrl;
    logic       i_clk_sys = 1'b0;
    logic       i_resetn  = 1'b0;
    logic       wr_req    = 1'b0;
    logic       rd_req    = 1'b0;
    logic       shared    = 1'b0;
    logic       tx_only   = 1'b0;
    logic       rx_only   = 1'b0;
    logic [5:0] swing     = 6'h0;
    logic [9:0] preemp    = 10'h0;
    logic [3:0] dcgain    = 4'h0;
    logic [7:0] eq        = 8'h0;
    logic       accept, busy, rd_valid;
    logic [5:0] swing_rb;
    logic [9:0] preemp_rb;
    logic [3:0] dcgain_rb;
    logic [7:0] eq_rb;
    int         err_count = 0;
    int         checks    = 0;

    always #12.5 i_clk_sys = ~i_clk_sys;

    afe_if afe_bus ();
    afe_ctrl i_afe_ctrl (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .bus(afe_bus));
    afe_user i_afe_user (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_wr_req(wr_req),
        .i_rd_req(rd_req), .i_shared(shared), .i_tx_only(tx_only), .i_rx_only(rx_only),
        .i_swing(swing), .i_preemp(preemp), .i_dcgain(dcgain), .i_eq(eq),
        .o_accept(accept), .o_busy(busy), .o_rd_valid(rd_valid), .o_swing(swing_rb),
        .o_preemp(preemp_rb), .o_dcgain(dcgain_rb), .o_eq(eq_rb), .bus(afe_bus));
    afe_ctrl_sva i_afe_ctrl_sva (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
        .write_all(afe_bus.write_all), .read(afe_bus.read), .dir_sel(afe_bus.dir_sel),
        .swing(afe_bus.swing), .preemp(afe_bus.preemp), .dcgain(afe_bus.dcgain),
        .eq(afe_bus.eq), .busy(afe_bus.busy), .data_valid(afe_bus.data_valid),
        .swing_out(afe_bus.swing_out), .dcgain_out(afe_bus.dcgain_out));

    // ==========================================
    // checking and closing
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("counts: checks=%0d mismatches=%0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ==========================================
    // access tasks
    // settings stay put until the next write, so they hold through each transfer
    task automatic op(input logic wr, input logic rd, input logic [1:0] dir, input logic sh,
                      input logic [5:0] sw, input logic [9:0] pe, input logic [3:0] dc,
                      input logic [7:0] q);
        int n;
        @(posedge i_clk_sys);
        #1;
        wr_req  = wr;
        rd_req  = rd;
        shared  = sh;
        tx_only = (dir == 2'h2);
        rx_only = (dir == 2'h1);
        swing   = sw;
        preemp  = pe;
        dcgain  = dc;
        eq      = q;
        n = 0;
        do begin
            @(negedge i_clk_sys);
            n++;
        end while (accept !== 1'b1 && n < 20);
        check({15'h0, accept}, 16'h1);
        @(posedge i_clk_sys);
        #1;
        wr_req = 1'b0;
        rd_req = 1'b0;
        n = 0;
        do begin
            @(negedge i_clk_sys);
            n++;
        end while (busy !== 1'b0 && n < 40);
        check({15'h0, busy}, 16'h0);
        check(16'(n), 16'(afe_pkg::NUM_CH * afe_pkg::CH_CYCLES + 2));
    endtask

    task automatic wr_op(input logic [1:0] dir, input logic sh, input logic [5:0] sw,
                         input logic [9:0] pe, input logic [3:0] dc, input logic [7:0] q);
        op(1'b1, 1'b0, dir, sh, sw, pe, dc, q);
        check({15'h0, rd_valid}, 16'h0);
    endtask

    task automatic rd_chk(input logic [1:0] dir, input logic [5:0] sw, input logic [9:0] pe,
                          input logic [3:0] dc, input logic [7:0] q);
        op(1'b0, 1'b1, dir, shared, swing, preemp, dcgain, eq);
        check({15'h0, rd_valid}, 16'h1);
        check({10'h0, swing_rb}, {10'h0, sw});
        check({6'h0, preemp_rb}, {6'h0, pe});
        check({12'h0, dcgain_rb}, {12'h0, dc});
        check({8'h0, eq_rb}, {8'h0, q});
        $display("test at %0t done", $time);
    endtask

    // ==========================================
    // tests
    initial begin
        repeat (4) @(posedge i_clk_sys);
        #1;
        i_resetn = 1'b1;
        check({10'h0, swing_rb}, 16'h0);
        check({15'h0, rd_valid}, 16'h0);
        $display("test reset done");
        wr_op(2'h3, 1'b1, 6'h15, 10'h093, 4'h6, 8'h3a);
        rd_chk(2'h3, 6'h2d, 10'h273, 4'ha, 8'haa);
        wr_op(2'h3, 1'b0, 6'h31, 10'h3e0, 4'hd, 8'hc5);
        rd_chk(2'h3, 6'h31, 10'h3e0, 4'hd, 8'hc5);
        wr_op(2'h2, 1'b0, 6'h17, 10'h155, 4'h0, 8'h00);
        rd_chk(2'h3, 6'h17, 10'h155, 4'hd, 8'hc5);
        wr_op(2'h1, 1'b0, 6'h00, 10'h000, 4'h8, 8'h96);
        rd_chk(2'h3, 6'h17, 10'h155, 4'h8, 8'h96);
        rd_chk(2'h2, 6'h17, 10'h155, 4'h8, 8'h96);
        rd_chk(2'h1, 6'h17, 10'h155, 4'h8, 8'h96);
        wr_op(2'h3, 1'b0, {3'h4, swing_rb[2:0]}, preemp_rb, dcgain_rb, eq_rb);
        rd_chk(2'h3, 6'h27, 10'h155, 4'h8, 8'h96);
        // both requests at once: the write is taken, the read dropped
        op(1'b1, 1'b1, 2'h3, 1'b1, 6'h03, 10'h001, 4'h1, 8'h01);
        check({15'h0, rd_valid}, 16'h0);
        rd_chk(2'h3, 6'h1b, 10'h021, 4'h5, 8'h11);
        test_done();
    end

    // about 160 cycles expected, so 2000 is ample
    initial begin
        #50000;
        err_count++;
        test_done();
    end
endmodule
